// File: logic/tmin_ceiling_pkg.sv
package tmin_ceiling_pkg;

  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] interval_off      = 8'h37;
  localparam logic [7:0] interval_msb_off  = 8'h36;
  localparam logic [7:0] ceiling1_off      = 8'h38;
  localparam logic [7:0] ceiling2_off      = 8'h39;
  localparam logic [7:0] ceiling3_off      = 8'h3A;
  localparam logic [7:0] config1_off       = 8'h40;

  // ----------------------------------------------------------------
  // fields and reset values
  // ----------------------------------------------------------------
  localparam int         interval_lo_pos   = 6;
  localparam int         interval_msb_pos  = 0;
  localparam int         lock_pos          = 1;
  localparam logic [7:0] ceiling_rst       = 8'hFF;
  localparam logic [7:0] interval_rst      = 8'h00;
  localparam logic [7:0] interval_msb_rst  = 8'h00;
  localparam logic [7:0] config1_rst       = 8'h01;

  // ----------------------------------------------------------------
  // adjustment waits, in monitoring cycles
  // ----------------------------------------------------------------
  localparam logic [11:0] dec_wait_base    = 12'h008;
  localparam logic [11:0] inc_wait_base    = 12'h010;

endpackage : tmin_ceiling_pkg

// File: logic/tmin_ceiling_regs.sv
// What this block does
// - remote 2 interval low bits sit in bits 7:6; high bit from register 0x36
// - interval code sets waits: 8/16 cycles at 000, doubling each step
// - with lock set, interval and ceiling registers ignore all writes
// - three ceiling registers at consecutive addresses, each resetting to 0xFF
// - each output duty is clamped to its own ceiling value
// - lock bit is write-once and holds until power cycle
`timescale 1ns/1ns
module tmin_ceiling_regs
(
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  output logic      [7:0]  reg_rdata,
  output logic             reg_hit,
  input  wire logic        monitor_tick,
  input  wire logic        dec_request,
  input  wire logic        inc_request,
  output logic             dec_apply,
  output logic             inc_apply,
  output logic      [2:0]  remote2_adjust_interval,
  input  wire logic [7:0]  loop_duty_1,
  input  wire logic [7:0]  loop_duty_2,
  input  wire logic [7:0]  loop_duty_3,
  output logic      [7:0]  fan_drive_output_1,
  output logic      [7:0]  fan_drive_output_2,
  output logic      [7:0]  fan_drive_output_3,
  output logic             lock_state
);

  import tmin_ceiling_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0]  interval;
    logic [7:0]  interval_msb;
    logic [7:0]  ceil1;
    logic [7:0]  ceil2;
    logic [7:0]  ceil3;
    logic [7:0]  config1;
    logic [11:0] dec_cnt;
    logic [11:0] inc_cnt;
    logic        dec_pulse;
    logic        inc_pulse;
    logic [7:0]  rdata;
    logic [7:0]  duty1;
    logic [7:0]  duty2;
    logic [7:0]  duty3;
  } state_s;

  state_s        st_reg;
  state_s        st_next;
  logic   [2:0]  code;
  logic   [11:0] dec_wait;
  logic   [11:0] inc_wait;
  logic          locked;
  logic          wr_allowed;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // duty never above its ceiling
  function automatic logic [7:0] clamp(input logic [7:0] want, input logic [7:0] ceil);
    clamp = (want > ceil) ? ceil : want;
  endfunction : clamp

  // each code step doubles the wait
  function automatic logic [11:0] wait_span(input logic [11:0] base, input logic [2:0] sel);
    wait_span = base << sel;
  endfunction : wait_span

  // stops at the wait so an idle counter cannot wrap
  function automatic logic [11:0] count_up(input logic [11:0] cnt, input logic [11:0] span);
    if (cnt < span)
      count_up = cnt + 12'h001;
    else
      count_up = cnt;
  endfunction : count_up

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  // addresses this block answers; all others read 0 and ignore writes
  function automatic logic is_mapped(input logic [7:0] addr);
    case (addr)
      interval_off,
      interval_msb_off,
      ceiling1_off,
      ceiling2_off,
      ceiling3_off,
      config1_off:
        is_mapped = 1'h1;
      default:
        is_mapped = 1'h0;
    endcase
  endfunction : is_mapped

  // stored register of the addressed slot
  function automatic logic [7:0] read_mux(input state_s st, input logic [7:0] addr);
    case (addr)
      interval_off:     read_mux = st.interval;
      interval_msb_off: read_mux = st.interval_msb;
      ceiling1_off:     read_mux = st.ceil1;
      ceiling2_off:     read_mux = st.ceil2;
      ceiling3_off:     read_mux = st.ceil3;
      config1_off:      read_mux = st.config1;
      default:          read_mux = 8'h00;
    endcase
  endfunction : read_mux

  // power-on contents; the lock only clears here
  function automatic state_s reset_state();
    reset_state              = '0;
    reset_state.interval     = interval_rst;
    reset_state.interval_msb = interval_msb_rst;
    reset_state.ceil1        = ceiling_rst;
    reset_state.ceil2        = ceiling_rst;
    reset_state.ceil3        = ceiling_rst;
    reset_state.config1      = config1_rst;
  endfunction : reset_state

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  assign code       = {st_reg.interval_msb[interval_msb_pos],
                       st_reg.interval[interval_lo_pos+1:interval_lo_pos]};
  assign dec_wait   = wait_span(dec_wait_base, code);
  assign inc_wait   = wait_span(inc_wait_base, code);
  assign locked     = st_reg.config1[lock_pos];
  assign wr_allowed = reg_wr && !locked && is_mapped(reg_addr);

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb
  begin
    st_next           = st_reg;
    st_next.dec_pulse = 1'h0;
    st_next.inc_pulse = 1'h0;

    // register writes, all refused once locked
    if (wr_allowed)
    begin
      case (reg_addr)
        interval_off:     st_next.interval     = reg_wdata;
        interval_msb_off: st_next.interval_msb = reg_wdata;
        ceiling1_off:     st_next.ceil1        = reg_wdata;
        ceiling2_off:     st_next.ceil2        = reg_wdata;
        ceiling3_off:     st_next.ceil3        = reg_wdata;
        config1_off:      st_next.config1      = reg_wdata;
        default:          st_next.config1      = st_reg.config1;
      endcase
    end

    // separate wait counters per direction
    if (monitor_tick)
    begin
      st_next.dec_cnt = count_up(st_reg.dec_cnt, dec_wait);
      st_next.inc_cnt = count_up(st_reg.inc_cnt, inc_wait);
    end

    // decrease granted once its wait has run out
    if (dec_request && st_reg.dec_cnt >= dec_wait)
    begin
      st_next.dec_pulse = 1'h1;
      st_next.dec_cnt   = 12'h000;
    end

    // increase granted once its own longer wait has run out
    if (inc_request && st_reg.inc_cnt >= inc_wait)
    begin
      st_next.inc_pulse = 1'h1;
      st_next.inc_cnt   = 12'h000;
    end

    // read data lags the address by one cycle
    st_next.rdata = read_mux(st_reg, reg_addr);

    // per-output ceiling clamp
    st_next.duty1 = clamp(loop_duty_1, st_reg.ceil1);
    st_next.duty2 = clamp(loop_duty_2, st_reg.ceil2);
    st_next.duty3 = clamp(loop_duty_3, st_reg.ceil3);
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  // synchronous reset to power-on contents
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      st_reg <= reset_state();
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  // ----------------------------------------------------------------
  // register bus outputs
  // ----------------------------------------------------------------
  assign reg_rdata               = st_reg.rdata;
  assign reg_hit                 = reg_rd && is_mapped(reg_addr);
  assign lock_state              = locked;

  // ----------------------------------------------------------------
  // loop outputs
  // ----------------------------------------------------------------
  assign dec_apply               = st_reg.dec_pulse;
  assign inc_apply               = st_reg.inc_pulse;
  assign remote2_adjust_interval = code;
  assign fan_drive_output_1      = st_reg.duty1;
  assign fan_drive_output_2      = st_reg.duty2;
  assign fan_drive_output_3      = st_reg.duty3;

endmodule : tmin_ceiling_regs

// File: tb/tmin_ceiling_monitor.sv
`timescale 1ns/1ns
module tmin_ceiling_monitor
(
  input wire logic       clk,
  input wire logic       rst_n,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_hit,
  input wire logic       dec_apply,
  input wire logic       inc_apply,
  input wire logic       inc_request,
  input wire logic [2:0] remote2_adjust_interval,
  input wire logic [7:0] loop_duty_1,
  input wire logic [7:0] fan_drive_output_1,
  input wire logic       lock_state
);
  import tmin_ceiling_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence dec_quiet;
    !dec_apply [*7];
  endsequence
  clamp_out_a: assert property (fan_drive_output_1 <= $past(loop_duty_1))
    else $error("output above requested duty");
  dec_spacing_a: assert property (dec_apply |=> dec_quiet)
    else $error("decrease grants too close");
  inc_grant_a: assert property (inc_apply |-> $past(inc_request))
    else $error("increase granted without request");
  interval_wr_a: assert property (reg_wr && reg_addr == interval_off && !lock_state
    |=> remote2_adjust_interval[1:0] == $past(reg_wdata) >> 6) else $error("interval not written");
  lock_hold_a: assert property (lock_state && reg_wr |=> $stable(remote2_adjust_interval))
    else $error("locked interval changed");
  lock_stick_a: assert property (lock_state |=> lock_state)
    else $error("lock cleared");
  ceiling_hit_a: assert property (reg_rd && reg_addr == ceiling1_off |-> reg_hit)
    else $error("ceiling read not mapped");
endmodule : tmin_ceiling_monitor
bind tmin_ceiling_regs tmin_ceiling_monitor i_tmin_ceiling_monitor (.*);

// File: tb/tmin_ceiling_regs_tb_top.sv
`timescale 1ns/1ns
module tmin_ceiling_regs_tb_top;
  import tmin_ceiling_pkg::*;
  logic clk = 1'h0, rst_n = 1'h0, reg_wr = 1'h0, reg_rd = 1'h0, monitor_tick = 1'h0;
  logic dec_request = 1'h0, inc_request = 1'h0, reg_hit, dec_apply, inc_apply, lock_state;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, da = 8'h00, ia = 8'h00;
  logic [7:0] loop_duty_1 = 8'hFF, loop_duty_2 = 8'h10, loop_duty_3 = 8'h00;
  logic [7:0] fan_drive_output_1, fan_drive_output_2, fan_drive_output_3;
  logic [2:0] remote2_adjust_interval;
  int fails = 0, check_count = 0;
  tmin_ceiling_regs i_tmin_ceiling_regs (.*);
  initial forever #5 clk = ~clk;
  always @(posedge clk)
  begin
    da <= da + 8'(dec_apply);
    ia <= ia + 8'(inc_apply);
  end
  task automatic step(int n);
    repeat (n) @(posedge clk) #1;
  endtask : step
  task automatic chk(logic [7:0] got, logic [7:0] exp);
    check_count++;
    if (got !== exp)
    begin
      fails++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(logic [7:0] a, logic [7:0] d);
    reg_wr = 1'h1;
    reg_addr = a;
    reg_wdata = d;
    step(1);
    reg_wr = 1'h0;
    step(1);
  endtask : wr
  task automatic rd(logic [7:0] a, logic [7:0] e, logic h);
    reg_addr = a;
    reg_rd = 1'h1;
    step(1);
    chk({7'h00, reg_hit}, {7'h00, h});
    reg_rd = 1'h0;
    chk(reg_rdata, e);
    step(1);
  endtask : rd
  task automatic tick(int n);
    monitor_tick = 1'h1;
    step(n);
    monitor_tick = 1'h0;
    step(3);
  endtask : tick
  task automatic close_out;
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : close_out
  initial
  begin
    #20000;
    fails++;
    close_out();
  end
  initial
  begin
    step(3);
    rst_n = 1'h1;
    rd(ceiling1_off, 8'hFF, 1'h1);
    rd(ceiling2_off, 8'hFF, 1'h1);
    rd(ceiling3_off, 8'hFF, 1'h1);
    rd(8'h55, 8'h00, 1'h0);
    $display("reset test done");
    dec_request = 1'h1;
    inc_request = 1'h1;
    tick(7);
    chk(da, 8'h00);
    tick(1);
    chk(da, 8'h01);
    chk(ia, 8'h00);
    tick(8);
    chk(ia, 8'h01);
    dec_request = 1'h0;
    inc_request = 1'h0;
    $display("wait test done");
    wr(interval_off, 8'h40);
    chk({5'h00, remote2_adjust_interval}, 8'h01);
    dec_request = 1'h1;
    tick(15);
    chk(da, 8'h02);
    tick(1);
    chk(da, 8'h03);
    dec_request = 1'h0;
    $display("doubling test done");
    wr(interval_off, 8'hC0);
    wr(interval_msb_off, 8'h01);
    chk({5'h00, remote2_adjust_interval}, 8'h07);
    rd(interval_off, 8'hC0, 1'h1);
    wr(ceiling1_off, 8'h80);
    step(1);
    chk(fan_drive_output_1, 8'h80);
    chk(fan_drive_output_2, 8'h10);
    chk(fan_drive_output_3, 8'h00);
    $display("interval and clamp test done");
    wr(config1_off, 8'h03);
    step(1);
    chk({7'h00, lock_state}, 8'h01);
    wr(ceiling2_off, 8'h55);
    rd(ceiling2_off, 8'hFF, 1'h1);
    wr(interval_off, 8'h00);
    chk({5'h00, remote2_adjust_interval}, 8'h07);
    wr(config1_off, 8'h00);
    step(1);
    chk({7'h00, lock_state}, 8'h01);
    $display("lock test done");
    close_out();
  end
endmodule : tmin_ceiling_regs_tb_top
